// ---- logic/tofs_pkg.sv ----
// Constants shared by the torque-off fault supervisor: register map, fields, resets, timing.
// Assumes a 200 MHz pclk and a 32-bit APB register bus.
`default_nettype none
package tofs_pkg;
    localparam int          CLK_HZ          = 200_000_000;
    localparam int          CYC_PER_MS      = CLK_HZ / 1000;
    // Register byte offsets.
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_STAT        = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT    = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h0c;
    localparam logic [7:0]  OFS_CUR_LIMIT   = 8'h10;
    localparam logic [7:0]  OFS_STALL_CUR   = 8'h14;
    localparam logic [7:0]  OFS_STALL_MS    = 8'h18;
    localparam logic [7:0]  OFS_OV_THRESH   = 8'h1c;
    // Control fields.
    localparam int          CTRL_TI_EN      = 0;
    localparam int          CTRL_TCP_EN     = 1;
    localparam int          CTRL_CAN_EN     = 2;
    localparam logic [2:0]  CTRL_RESET      = 3'h2;
    // Status and interrupt fields.
    localparam int          EV_TI_FAULT     = 0;
    localparam int          EV_STALL        = 1;
    localparam int          EV_SHORT        = 2;
    localparam int          EV_OVERVOLT     = 3;
    localparam int          EV_SELFTEST     = 4;
    localparam int          EV_W            = 5;
    localparam int          STAT_POWER_OK   = 5;
    localparam int          STAT_TEST_BUSY  = 6;
    // Analog quantities: current in 0.1 A steps, voltage in 0.1 V steps.
    localparam int          AMP_W           = 10;
    localparam logic [9:0]  CUR_MAX         = 10'h258;
    localparam logic [9:0]  CUR_LIMIT_RESET = 10'h1f4;
    localparam logic [9:0]  STALL_CUR_RESET = 10'h258;
    localparam logic [9:0]  OV_RESET        = 10'h258;
    localparam logic [15:0] STALL_MS_RESET  = 16'h01f4;
    localparam logic [15:0] STALL_MS_MIN    = 16'h0001;
    localparam logic [15:0] STALL_MS_MAX    = 16'hfde8;
    // Timing.
    localparam int          LED_PERIOD_MS   = 2000;
    localparam int          SELFTEST_MS     = 1080;
endpackage
`default_nettype wire

// ---- logic/tofs_sync2.sv ----
// Two-flop synchroniser for a bus of asynchronous pins.
// Assumes each bit may change at any time relative to pclk.
`default_nettype none
module tofs_sync2 #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// ---- logic/tofs_ms_tick.sv ----
// Free-running divider producing a one-cycle pulse every millisecond.
// Assumes pclk at the rate given in the package; CYC is shortened in simulation.
`default_nettype none
module tofs_ms_tick #(
    parameter int CYC = tofs_pkg::CYC_PER_MS
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    logic [31:0] cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (cnt == 32'(CYC - 1)) begin
            cnt  <= '0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- logic/tofs_top.sv ----
// Torque-off fault supervisor: gates the power stage, self-tests the inhibit path,
// detects stall, short and overvoltage, keeps link modes exclusive and drives indicators.
// Assumes APB from software; inhibit pins and the short and test-loopback pins are asynchronous.
// Operation
// [RULE_01] The power stage is enabled only while both inhibit inputs are high.
// [RULE_02] A self-test of the inhibit path runs at power-on and each time both inputs become high.
// [RULE_03] Energizing needs a passed self-test; a failed test or inputs not both high cut the stage.
// [RULE_04] Exactly one input high keeps the stage off and raises the inhibit fault.
// [RULE_05] The safety equipment drives both inputs low together or both high together.
// [RULE_06] Checking is bypassed unless the jumper is removed and the enable bit is set.
// [RULE_07] TCP and CAN link modes are never both active.
// [RULE_08] After reset TCP link mode is on and CAN link mode is off.
// [RULE_09] The power indicator is steady and the status indicator flashes with a two second period.
// [RULE_10] Stall is declared when current stays above the stall current for 1 to 65000 ms, default 500.
// [RULE_11] A short circuit stops driving until a zero motion command is seen.
// [RULE_12] A current limit in 0.1 A steps up to 60 A clamps the motor current.
// [RULE_13] A supply overvoltage threshold in 0.1 V steps stops driving when exceeded.
// [RULE_14] Inhibit fault, stall and short are status flags that persist until cleared.
`default_nettype none
module tofs_top #(
    parameter int MS_CYC = tofs_pkg::CYC_PER_MS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        torque_inhibit_in_a,
    input  wire logic        torque_inhibit_in_b,
    input  wire logic        bypass_jumper,
    input  wire logic        selftest_echo,
    input  wire logic        short_detect,
    input  wire logic        zero_command,
    input  wire logic [9:0]  motor_current,
    input  wire logic [9:0]  supply_voltage,
    input  wire logic [9:0]  current_demand,
    output logic [9:0]       current_command,
    output logic             power_stage_en,
    output logic             selftest_probe,
    output logic             tcp_mode,
    output logic             can_mode,
    output logic             power_led,
    output logic             status_led,
    output logic             irq
);
    typedef enum logic [1:0] {
        TOFS_IDLE = 2'b00,
        TOFS_TEST = 2'b01,
        TOFS_PASS = 2'b11,
        TOFS_FAIL = 2'b10
    } tofs_test_t;

    localparam int ST_CYC = tofs_pkg::SELFTEST_MS;
    localparam int LED_HALF = tofs_pkg::LED_PERIOD_MS / 2;

    logic [4:0]  pins_s;
    logic        ti_a, ti_b, jumper, echo, short_s;
    logic        ms_tick;
    tofs_test_t  test_st;
    logic [15:0] test_ms;
    logic        both_d;
    logic        ctrl_ti_en, ctrl_tcp, ctrl_can;
    logic [tofs_pkg::EV_W-1:0] ev_stat, ev_mask, ev_set;
    logic [9:0]  cur_limit, stall_cur, ov_thresh;
    logic [15:0] stall_ms, stall_cnt;
    logic        short_latched;
    logic        stall_hit;
    logic [10:0] led_cnt;
    logic        checking, both_high, one_high, drive_ok;
    logic        wr_en, rd_en;
    logic [31:0] next_prdata;

    tofs_sync2 #(.W(5)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({torque_inhibit_in_a, torque_inhibit_in_b, bypass_jumper, selftest_echo, short_detect}),
        .q       (pins_s)
    );
    assign {ti_a, ti_b, jumper, echo, short_s} = pins_s;

    tofs_ms_tick #(.CYC(MS_CYC)) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (ms_tick)
    );

    // Clamps a current value in 0.1 A steps to the given limit.
    function automatic logic [9:0] clamp_amp(input logic [9:0] v, input logic [9:0] lim);
        clamp_amp = (v > lim) ? lim : v;
    endfunction

    // The jumper input is high while the bypass jumper is fitted.
    assign checking  = !jumper && ctrl_ti_en;                           // see [RULE_06]
    assign both_high = ti_a && ti_b;
    assign one_high  = ti_a ^ ti_b;                                     // see [RULE_05]
    assign wr_en     = psel && penable && pwrite;
    assign rd_en     = psel && penable && !pwrite;

    // Self-test: the probe toggles once per ms; the echo must follow for the whole test time.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_st        <= TOFS_TEST;                                // see [RULE_02]
            test_ms        <= '0;
            both_d         <= 1'b0;
            selftest_probe <= 1'b0;
        end else begin
            both_d <= both_high;
            if (both_high && !both_d) begin
                // The probe keeps its phase so the echo compared at the next tick has settled.
                test_st        <= TOFS_TEST;                            // see [RULE_02]
                test_ms        <= '0;
            end else if (test_st == TOFS_TEST) begin
                if (echo != selftest_probe && ms_tick) begin
                    test_st <= TOFS_FAIL;                               // see [RULE_03]
                end else if (ms_tick) begin
                    selftest_probe <= !selftest_probe;
                    if (test_ms == 16'(ST_CYC - 1)) begin
                        test_st        <= TOFS_PASS;
                        selftest_probe <= 1'b0;
                    end
                    test_ms <= test_ms + 16'h1;
                end
            end
        end
    end

    // Stall timer counts ms while current exceeds the stall level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_cnt <= '0;
        end else if (motor_current <= stall_cur) begin
            stall_cnt <= '0;
        end else if (ms_tick && stall_cnt != 16'hffff) begin
            stall_cnt <= stall_cnt + 16'h1;
        end
    end
    assign stall_hit = ms_tick && (stall_cnt + 16'h1 == stall_ms);     // see [RULE_10]

    // Short latch released only by a zero motion command once the short is gone.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_latched <= 1'b0;
        end else if (short_s) begin
            short_latched <= 1'b1;                                      // see [RULE_11]
        end else if (zero_command) begin
            short_latched <= 1'b0;
        end
    end

    assign drive_ok = (!checking || (both_high && test_st == TOFS_PASS))   // see [RULE_01] see [RULE_03]
                    && !short_latched && !short_s
                    && (supply_voltage <= ov_thresh);                   // see [RULE_13]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_stage_en  <= 1'b0;
            current_command <= '0;
        end else begin
            power_stage_en  <= drive_ok;                                // see [RULE_04]
            current_command <= drive_ok ? clamp_amp(current_demand, cur_limit) : '0;   // see [RULE_12]
        end
    end

    always_comb begin
        ev_set = '0;
        ev_set[tofs_pkg::EV_TI_FAULT] = checking && one_high;           // see [RULE_04]
        ev_set[tofs_pkg::EV_STALL]    = stall_hit;
        ev_set[tofs_pkg::EV_SHORT]    = short_s;
        ev_set[tofs_pkg::EV_OVERVOLT] = supply_voltage > ov_thresh;
        ev_set[tofs_pkg::EV_SELFTEST] = checking && test_st == TOFS_FAIL;
    end

    // Sticky event flags, write one to clear; a new event wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_stat <= '0;
        end else if (wr_en && paddr == tofs_pkg::OFS_IRQ_STAT) begin
            ev_stat <= (ev_stat & ~pwdata[tofs_pkg::EV_W-1:0]) | ev_set;   // see [RULE_14]
        end else begin
            ev_stat <= ev_stat | ev_set;
        end
    end

    // Register writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ti_en <= tofs_pkg::CTRL_RESET[tofs_pkg::CTRL_TI_EN];
            ctrl_tcp   <= tofs_pkg::CTRL_RESET[tofs_pkg::CTRL_TCP_EN];  // see [RULE_08]
            ctrl_can   <= tofs_pkg::CTRL_RESET[tofs_pkg::CTRL_CAN_EN];
            ev_mask    <= '0;
            cur_limit  <= tofs_pkg::CUR_LIMIT_RESET;
            stall_cur  <= tofs_pkg::STALL_CUR_RESET;
            stall_ms   <= tofs_pkg::STALL_MS_RESET;
            ov_thresh  <= tofs_pkg::OV_RESET;
        end else if (wr_en && pstrb[0]) begin
            case (paddr)
                tofs_pkg::OFS_CTRL: begin
                    ctrl_ti_en <= pwdata[tofs_pkg::CTRL_TI_EN];
                    // A write asking for both link modes is ignored for the link bits.
                    if (!(pwdata[tofs_pkg::CTRL_TCP_EN] && pwdata[tofs_pkg::CTRL_CAN_EN])) begin
                        ctrl_tcp <= pwdata[tofs_pkg::CTRL_TCP_EN];      // see [RULE_07]
                        ctrl_can <= pwdata[tofs_pkg::CTRL_CAN_EN];
                    end
                end
                tofs_pkg::OFS_IRQ_MASK:  ev_mask   <= pwdata[tofs_pkg::EV_W-1:0];
                tofs_pkg::OFS_CUR_LIMIT: cur_limit <= clamp_amp(pwdata[9:0], tofs_pkg::CUR_MAX);
                tofs_pkg::OFS_STALL_CUR: stall_cur <= clamp_amp(pwdata[9:0], tofs_pkg::CUR_MAX);
                tofs_pkg::OFS_STALL_MS: begin
                    if (pwdata[15:0] < tofs_pkg::STALL_MS_MIN) begin
                        stall_ms <= tofs_pkg::STALL_MS_MIN;
                    end else if (pwdata[15:0] > tofs_pkg::STALL_MS_MAX) begin
                        stall_ms <= tofs_pkg::STALL_MS_MAX;             // see [RULE_10]
                    end else begin
                        stall_ms <= pwdata[15:0];
                    end
                end
                tofs_pkg::OFS_OV_THRESH: ov_thresh <= pwdata[9:0];      // see [RULE_13]
                default: ;
            endcase
        end
    end

    always_comb begin
        next_prdata = '0;
        case (paddr)
            tofs_pkg::OFS_CTRL:      next_prdata[2:0] = {ctrl_can, ctrl_tcp, ctrl_ti_en};
            tofs_pkg::OFS_STAT: begin
                next_prdata[tofs_pkg::EV_TI_FAULT]    = checking && one_high;
                next_prdata[tofs_pkg::EV_STALL]       = stall_cnt >= stall_ms;
                next_prdata[tofs_pkg::EV_SHORT]       = short_latched;
                next_prdata[tofs_pkg::EV_OVERVOLT]    = supply_voltage > ov_thresh;
                next_prdata[tofs_pkg::EV_SELFTEST]    = test_st == TOFS_FAIL;
                next_prdata[tofs_pkg::STAT_POWER_OK]  = power_stage_en;
                next_prdata[tofs_pkg::STAT_TEST_BUSY] = test_st == TOFS_TEST;
            end
            tofs_pkg::OFS_IRQ_STAT:  next_prdata[tofs_pkg::EV_W-1:0] = ev_stat;
            tofs_pkg::OFS_IRQ_MASK:  next_prdata[tofs_pkg::EV_W-1:0] = ev_mask;
            tofs_pkg::OFS_CUR_LIMIT: next_prdata[9:0] = cur_limit;
            tofs_pkg::OFS_STALL_CUR: next_prdata[9:0] = stall_cur;
            tofs_pkg::OFS_STALL_MS:  next_prdata[15:0] = stall_ms;
            tofs_pkg::OFS_OV_THRESH: next_prdata[9:0] = ov_thresh;
            default:                 next_prdata = '0;
        endcase
    end

    // APB answers in the access cycle; unmapped offsets give an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr[1:0] != 2'b00 || paddr > tofs_pkg::OFS_OV_THRESH);
            prdata  <= (psel && !penable && !pwrite) ? next_prdata : prdata;
        end
    end

    // Indicators and link mode outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_cnt    <= '0;
            status_led <= 1'b0;
            power_led  <= 1'b0;
            tcp_mode   <= 1'b0;
            can_mode   <= 1'b0;
            irq        <= 1'b0;
        end else begin
            power_led <= 1'b1;                                          // see [RULE_09]
            if (ms_tick) begin
                if (led_cnt == 11'(LED_HALF - 1)) begin
                    led_cnt    <= '0;
                    status_led <= !status_led;                          // see [RULE_09]
                end else begin
                    led_cnt <= led_cnt + 11'h1;
                end
            end
            tcp_mode <= ctrl_tcp && !ctrl_can;                          // see [RULE_07]
            can_mode <= ctrl_can && !ctrl_tcp;
            irq      <= |(ev_stat & ev_mask);
        end
    end
    logic unused_ok;
    assign unused_ok = rd_en ^ (|pstrb[3:1]);
endmodule
`default_nettype wire

// ---- test/tofs_top_monitor.sv ----
// Port-level assertions for the torque-off fault supervisor.
// Assumes inhibit checking is on whenever the jumper is out and an inhibit input is high.
`default_nettype none
module tofs_top_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       torque_inhibit_in_a,
    input wire logic       torque_inhibit_in_b,
    input wire logic       bypass_jumper,
    input wire logic       short_detect,
    input wire logic [9:0] current_command,
    input wire logic       power_stage_en,
    input wire logic       tcp_mode,
    input wire logic       can_mode,
    input wire logic       power_led
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_split;
        (torque_inhibit_in_a != torque_inhibit_in_b) [*5];
    endsequence
    chk_stage_both: assert property ($rose(power_stage_en) && !bypass_jumper |->
        torque_inhibit_in_a && torque_inhibit_in_b) else $error("stage rose without both inputs high");
    chk_drop_stage: assert property ($fell(torque_inhibit_in_a && torque_inhibit_in_b) |->
        ##[1:5] !power_stage_en) else $error("stage not cut after inputs fell");
    chk_split_off: assert property (s_split |-> !power_stage_en) else $error("stage on with split inputs");
    chk_links_excl: assert property (!(tcp_mode && can_mode)) else $error("both link modes active");
    chk_reset_modes: assert property ($rose(presetn) |=> tcp_mode && !can_mode && power_led)
        else $error("wrong modes after reset");
    chk_led_steady: assert property (power_led |=> power_led) else $error("power indicator dropped");
    chk_short_off: assert property (short_detect [*5] |-> !power_stage_en) else $error("stage on during short");
    chk_cmd_max: assert property (current_command <= tofs_pkg::CUR_MAX) else $error("command above maximum");
    chk_apb_ready: assert property (s_setup |=> pready) else $error("no ready in first access cycle");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
endmodule
bind tofs_top tofs_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .torque_inhibit_in_a(torque_inhibit_in_a), .torque_inhibit_in_b(torque_inhibit_in_b),
    .bypass_jumper(bypass_jumper), .short_detect(short_detect), .current_command(current_command),
    .power_stage_en(power_stage_en), .tcp_mode(tcp_mode), .can_mode(can_mode), .power_led(power_led));
`default_nettype wire

// ---- test/tofs_safety_relay.sv ----
// Model of the external safety controller driving both inhibit lines and the test loopback.
// Assumes want is set by the bench; break_echo models a failed inhibit path.
`default_nettype none
module tofs_safety_relay (
    input wire logic       pclk,
    input wire logic [1:0] want,
    input wire logic       break_echo,
    input wire logic       selftest_probe,
    output logic           ti_a,
    output logic           ti_b,
    output logic           echo
);
    timeunit 1ns;
    timeprecision 1ps;
    initial ti_a = 1'b0;
    initial ti_b = 1'b0;
    // Both lines move on the same edge so a requested run or release is never split.
    always @(posedge pclk) begin
        ti_a <= want[0];
        ti_b <= want[1];
    end
    assign echo = break_echo ? 1'b0 : selftest_probe;
endmodule
`default_nettype wire

// ---- test/tofs_top_test.sv ----
// Self-checking bench for the torque-off fault supervisor with a register model.
// Assumes MS_CYC is shortened to 4 cycles per millisecond.
`default_nettype none
module tofs_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, seed = 32'h8cf261ac;
    logic [9:0]  motor_current = 0, supply_voltage = 0, current_demand = 0, current_command, d;
    logic [1:0]  want = 0;
    logic ti_a, ti_b, echo, probe, break_echo = 0, short_detect = 0, zero_command = 0, bypass_jumper = 1, e;
    logic power_stage_en, tcp_mode, can_mode, power_led, status_led;
    int   n_fail = 0, samples_checked = 0, i, n;
    int   m[8] = '{2, 0, 0, 0, 500, 600, 500, 600};
    always #2.5 pclk = ~pclk;
    tofs_top #(.MS_CYC(MS)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .torque_inhibit_in_a(ti_a), .torque_inhibit_in_b(ti_b), .bypass_jumper(bypass_jumper),
        .selftest_echo(echo), .short_detect(short_detect), .zero_command(zero_command),
        .motor_current(motor_current), .supply_voltage(supply_voltage), .current_demand(current_demand),
        .current_command(current_command), .power_stage_en(power_stage_en), .selftest_probe(probe),
        .tcp_mode(tcp_mode), .can_mode(can_mode), .power_led(power_led), .status_led(status_led), .irq(irq));
    tofs_safety_relay u_rel (.pclk(pclk), .want(want), .break_echo(break_echo), .selftest_probe(probe),
        .ti_a(ti_a), .ti_b(ti_b), .echo(echo));
    function logic [31:0] xrand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task results();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
        samples_checked++;
        if (s !== ex) begin
            $display("BAD %s expected %h seen %h", nm, ex, s);
            n_fail++;
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin n_fail++; results(); end
        r = prdata; e = pslverr; psel <= 0; penable <= 0;
    endtask
    task wr(input int ix, input logic [31:0] wd);
        apb(1, 8'(ix * 4), wd);
        case (ix)
            0: m[0] = (wd[1] && wd[2]) ? ((m[0] & 6) | wd[0]) : wd[2:0];
            3: m[3] = wd[4:0];
            4: m[4] = (wd[9:0] > 600) ? 600 : wd[9:0];
            5, 7: m[ix] = wd[9:0];
            6: m[6] = (wd[15:0] < 1) ? 1 : ((wd[15:0] > 65000) ? 65000 : wd[15:0]);
            default: ;
        endcase
    endtask
    task rdm(input int ix);
        apb(0, 8'(ix * 4), 0);
        chk("register", m[ix], r);
    endtask
    task bit_is(input int ix, input int b, input logic v);
        apb(0, 8'(ix * 4), 0);
        chk("status bit", v, r[b]);
    endtask
    task wait_stage(input logic v, input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            @(posedge pclk);
            if (power_stage_en === v) break;
        end
        if (k == lim) begin n_fail++; results(); end
    endtask
    task done(input string nm);
        $display("test %s done, %0d mismatches", nm, n_fail);
    endtask
    initial begin
        repeat (100000) @(posedge pclk);
        n_fail++;
        results();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        #1 chk("power_led", 1, power_led);
        chk("tcp_can", 2'b10, {tcp_mode, can_mode});
        chk("bypass_stage", 1, power_stage_en);
        foreach (m[k]) if (k != 1 && k != 2) rdm(k);
        apb(0, 8'h20, 0);
        chk("slverr", 1, e);
        done("reset");
        bypass_jumper <= 0;
        for (n = 0; n < 4; n++) begin
            wr(0, 32'(n * 2 + 1));
            rdm(0);
            #1 chk("links", m[0][2:1], {can_mode, tcp_mode});
        end
        wr(0, 3);
        done("links");
        chk("stage_off", 0, power_stage_en);
        want <= 3;
        d[0] = probe;
        repeat (MS) @(posedge pclk);
        chk("probe_toggle", !d[0], probe);
        wait_stage(1, MS * 1300);
        wr(4, 100);
        for (n = 0; n < 8; n++) begin
            d = 10'(xrand());
            current_demand <= d;
            repeat (4) @(posedge pclk);
            chk("command", (d > 100) ? 100 : d, current_command);
        end
        wr(4, 32'h3ff);
        rdm(4);
        current_demand <= 10'h3ff;
        repeat (4) @(posedge pclk);
        chk("command_max", 600, current_command);
        done("drive");
        supply_voltage <= 10'h259;
        wait_stage(0, 10);
        bit_is(1, 3, 1);
        supply_voltage <= 10'h258;
        wait_stage(1, 10);
        short_detect <= 1;
        wait_stage(0, 10);
        repeat (4) @(posedge pclk);
        short_detect <= 0;
        repeat (8) @(posedge pclk);
        bit_is(1, 2, 1);
        chk("short_hold", 0, power_stage_en);
        zero_command <= 1;
        repeat (2) @(posedge pclk);
        zero_command <= 0;
        wait_stage(1, 10);
        bit_is(1, 2, 0);
        done("faults");
        want <= 1;
        wait_stage(0, 10);
        bit_is(1, 0, 1);
        chk("irq_masked", 0, irq);
        wr(3, 1);
        repeat (2) @(posedge pclk);
        chk("irq_on", 1, irq);
        want <= 0;
        bit_is(2, 0, 1);
        wr(3, 0);
        repeat (2) @(posedge pclk);
        chk("irq_off", 0, irq);
        wr(2, 1);
        bit_is(2, 0, 0);
        done("split");
        break_echo <= 1;
        want <= 3;
        repeat (MS * 1200) @(posedge pclk);
        chk("test_fail", 0, power_stage_en);
        bit_is(1, 4, 1);
        done("selftest");
        wr(5, 100);
        wr(6, 3);
        motor_current <= 10'h065;
        bit_is(1, 1, 0);
        repeat (40) @(posedge pclk);
        bit_is(1, 1, 1);
        wr(6, 0);
        rdm(6);
        wr(6, 32'hffff);
        rdm(6);
        done("stall");
        d[0] = status_led;
        for (i = 0; i < MS * 1100 && status_led === d[0]; i++) @(posedge pclk);
        d[0] = status_led;
        for (i = 0; i < MS * 1100 && status_led === d[0]; i++) @(posedge pclk);
        chk("led_half_period", MS * 1000, i);
        done("led");
        results();
    end
endmodule
`default_nettype wire
